// ==== design/irqb_bank.sv ====
// Pending-flag and enable register bank with AXI4-Lite slave and summary interrupt
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module irqb_bank (
	input  wire logic                       CORE_CLK,
	input  wire logic                       ARST_N,
	input  wire irqb_pkg::irqb_flags_s      SRC_EVT,
	input  wire logic [irqb_pkg::REG_W-1:0] SRC0_FLAG,
	output var  irqb_pkg::irqb_flags_s      PEND_FLAGS,
	output logic      [irqb_pkg::REG_W-1:0] CPU_REQ0,
	output logic                            IRQ,
	input  wire logic [irqb_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic                       S_AXI_AWVALID,
	output logic                            S_AXI_AWREADY,
	input  wire logic [irqb_pkg::DATA_W-1:0] S_AXI_WDATA,
	input  wire logic [3:0]                 S_AXI_WSTRB,
	input  wire logic                       S_AXI_WVALID,
	output logic                            S_AXI_WREADY,
	output logic      [1:0]                 S_AXI_BRESP,
	output logic                            S_AXI_BVALID,
	input  wire logic                       S_AXI_BREADY,
	input  wire logic [irqb_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic                       S_AXI_ARVALID,
	output logic                            S_AXI_ARREADY,
	output logic      [irqb_pkg::DATA_W-1:0] S_AXI_RDATA,
	output logic      [1:0]                 S_AXI_RRESP,
	output logic                            S_AXI_RVALID,
	input  wire logic                       S_AXI_RREADY
);
	logic                        rst_meta_q;
	logic                        rst_n;
	irqb_pkg::irqb_flags_s       flags_q;
	irqb_pkg::irqb_flags_s       flags_d;
	logic [irqb_pkg::REG_W-1:0]  enable_q;
	logic [irqb_pkg::REG_W-1:0]  enable_d;
	logic [irqb_pkg::STAT_W-1:0] status_q;
	logic [irqb_pkg::STAT_W-1:0] status_d;
	logic [irqb_pkg::STAT_W-1:0] mask_q;
	logic [irqb_pkg::STAT_W-1:0] mask_d;
	logic [irqb_pkg::REG_W-1:0]  req_d;
	logic [irqb_pkg::ADDR_W-1:0] awaddr_q;
	logic [irqb_pkg::DATA_W-1:0] wdata_q;
	logic [3:0]                  wstrb_q;
	logic                        aw_have_q;
	logic                        w_have_q;
	irqb_pkg::irqb_chan_e        wr_state_q;
	irqb_pkg::irqb_chan_e        rd_state_q;

	// Release of the asynchronous reset through two flip-flops
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Write channel handshakes; address and data may arrive in either order
	wire aw_fire  = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_fire   = S_AXI_WVALID && S_AXI_WREADY;
	wire aw_has   = aw_have_q || aw_fire;
	wire w_has    = w_have_q || w_fire;
	wire wr_go    = (wr_state_q == irqb_pkg::CH_IDLE) && aw_has && w_has;
	wire b_fire   = S_AXI_BVALID && S_AXI_BREADY;
	wire [irqb_pkg::ADDR_W-1:0] wr_addr = aw_have_q ? awaddr_q : S_AXI_AWADDR;
	wire [irqb_pkg::DATA_W-1:0] wr_data = w_have_q ? wdata_q : S_AXI_WDATA;
	wire [3:0]                  wr_strb = w_have_q ? wstrb_q : S_AXI_WSTRB;

	wire wr_f5   = wr_go && (wr_addr == irqb_pkg::OFS_FLAGS5);
	wire wr_f6   = wr_go && (wr_addr == irqb_pkg::OFS_FLAGS6);
	wire wr_f7   = wr_go && (wr_addr == irqb_pkg::OFS_FLAGS7);
	wire wr_en0  = wr_go && (wr_addr == irqb_pkg::OFS_ENABLE0);
	wire wr_st   = wr_go && (wr_addr == irqb_pkg::OFS_STATUS);
	wire wr_msk  = wr_go && (wr_addr == irqb_pkg::OFS_MASK);
	wire wr_hit  = wr_f5 || wr_f6 || wr_f7 || wr_en0 || wr_st || wr_msk;

	// Byte lanes 0 and 1 carry the 16-bit registers; upper lanes have no storage
	wire [irqb_pkg::REG_W-1:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire [irqb_pkg::REG_W-1:0] wr_lo     = wr_data[irqb_pkg::REG_W-1:0];

	function automatic logic [irqb_pkg::REG_W-1:0] merge(
		input logic [irqb_pkg::REG_W-1:0] cur,
		input logic [irqb_pkg::REG_W-1:0] nw,
		input logic [irqb_pkg::REG_W-1:0] lanes
	);
		merge = (cur & ~lanes) | (nw & lanes);
	endfunction

	// Source events are masked to implemented positions before they touch a flag
	wire [irqb_pkg::REG_W-1:0] evt5 = SRC_EVT.f5 & irqb_pkg::IMPL_FLAGS5;
	wire [irqb_pkg::REG_W-1:0] evt6 = SRC_EVT.f6 & irqb_pkg::IMPL_FLAGS6;
	wire [irqb_pkg::REG_W-1:0] evt7 = SRC_EVT.f7 & irqb_pkg::IMPL_FLAGS7;

	// A source pulse wins over a software clear in the same cycle
	wire [irqb_pkg::REG_W-1:0] f5_base = wr_f5 ? merge(flags_q.f5, wr_lo, lane_mask) : flags_q.f5;
	wire [irqb_pkg::REG_W-1:0] f6_base = wr_f6 ? merge(flags_q.f6, wr_lo, lane_mask) : flags_q.f6;
	wire [irqb_pkg::REG_W-1:0] f7_base = wr_f7 ? merge(flags_q.f7, wr_lo, lane_mask) : flags_q.f7;
	assign flags_d.f5 = (f5_base | evt5) & irqb_pkg::IMPL_FLAGS5;
	assign flags_d.f6 = (f6_base | evt6) & irqb_pkg::IMPL_FLAGS6;
	assign flags_d.f7 = (f7_base | evt7) & irqb_pkg::IMPL_FLAGS7;
	assign enable_d = wr_en0 ? (merge(enable_q, wr_lo, lane_mask) & irqb_pkg::IMPL_ENABLE0)
	                         : enable_q;

	// Request to the core only where flag and enable are both set
	assign req_d = SRC0_FLAG & enable_q;

	// Event status: new forwarded request, or a pulse onto an already pending flag
	wire ev_fwd = |(req_d & ~CPU_REQ0);
	wire ev_ovr = |((evt5 & flags_q.f5) | (evt6 & flags_q.f6) | (evt7 & flags_q.f7));
	wire [irqb_pkg::STAT_W-1:0] ev_vec = {ev_ovr, ev_fwd};
	wire [irqb_pkg::STAT_W-1:0] st_lanes = lane_mask[irqb_pkg::STAT_W-1:0];
	wire [irqb_pkg::STAT_W-1:0] st_clr   = wr_st ? (wr_lo[irqb_pkg::STAT_W-1:0] & st_lanes)
	                                             : irqb_pkg::RST_STAT;
	// Mask is merged at register width, then cut to its two stored bits
	wire [irqb_pkg::REG_W-1:0]  mask_wide = merge({14'h0000, mask_q}, wr_lo, lane_mask);
	assign status_d = (status_q & ~st_clr) | ev_vec;
	assign mask_d   = wr_msk ? mask_wide[irqb_pkg::STAT_W-1:0] : mask_q;

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			flags_q  <= '0;
			enable_q <= irqb_pkg::RST_REG;
			status_q <= irqb_pkg::RST_STAT;
			mask_q   <= irqb_pkg::RST_STAT;
			CPU_REQ0 <= irqb_pkg::RST_REG;
			IRQ      <= 1'b0;
		end else begin
			flags_q  <= flags_d;
			enable_q <= enable_d;
			status_q <= status_d;
			mask_q   <= mask_d;
			CPU_REQ0 <= req_d;
			IRQ      <= |(status_d & mask_d);
		end
	end

	assign PEND_FLAGS = flags_q;

	// Write channel sequencing
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			awaddr_q     <= '0;
			wdata_q      <= '0;
			wstrb_q      <= 4'h0;
			wr_state_q   <= irqb_pkg::CH_IDLE;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= irqb_pkg::RESP_OKAY;
		end else begin
			if (aw_fire) begin
				awaddr_q <= S_AXI_AWADDR;
			end
			if (w_fire) begin
				wdata_q <= S_AXI_WDATA;
				wstrb_q <= S_AXI_WSTRB;
			end
			case (wr_state_q)
				irqb_pkg::CH_IDLE: begin
					if (wr_go) begin
						wr_state_q   <= irqb_pkg::CH_RESP;
						aw_have_q    <= 1'b0;
						w_have_q     <= 1'b0;
						S_AXI_AWREADY <= 1'b0;
						S_AXI_WREADY <= 1'b0;
						S_AXI_BVALID <= 1'b1;
						S_AXI_BRESP  <= wr_hit ? irqb_pkg::RESP_OKAY : irqb_pkg::RESP_SLVERR;
					end else begin
						aw_have_q    <= aw_has;
						w_have_q     <= w_has;
						S_AXI_AWREADY <= !aw_has;
						S_AXI_WREADY <= !w_has;
					end
				end
				irqb_pkg::CH_RESP: begin
					if (b_fire) begin
						wr_state_q   <= irqb_pkg::CH_IDLE;
						S_AXI_BVALID <= 1'b0;
						S_AXI_AWREADY <= 1'b1;
						S_AXI_WREADY <= 1'b1;
					end
				end
				default: begin
					wr_state_q <= irqb_pkg::CH_IDLE;
				end
			endcase
		end
	end

	// Read path; unmapped addresses answer zero with an error response
	wire ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
	wire rd_f5   = S_AXI_ARADDR == irqb_pkg::OFS_FLAGS5;
	wire rd_f6   = S_AXI_ARADDR == irqb_pkg::OFS_FLAGS6;
	wire rd_f7   = S_AXI_ARADDR == irqb_pkg::OFS_FLAGS7;
	wire rd_en0  = S_AXI_ARADDR == irqb_pkg::OFS_ENABLE0;
	wire rd_st   = S_AXI_ARADDR == irqb_pkg::OFS_STATUS;
	wire rd_msk  = S_AXI_ARADDR == irqb_pkg::OFS_MASK;
	wire rd_hit  = rd_f5 || rd_f6 || rd_f7 || rd_en0 || rd_st || rd_msk;
	wire [irqb_pkg::REG_W-1:0] rd_reg =
		rd_f5  ? flags_q.f5 :
		rd_f6  ? flags_q.f6 :
		rd_f7  ? flags_q.f7 :
		rd_en0 ? enable_q :
		rd_st  ? {14'h0000, status_q} :
		rd_msk ? {14'h0000, mask_q} : irqb_pkg::RST_REG;
	wire [irqb_pkg::DATA_W-1:0] rd_word = {16'h0000, rd_reg};

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rd_state_q    <= irqb_pkg::CH_IDLE;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= '0;
			S_AXI_RRESP   <= irqb_pkg::RESP_OKAY;
		end else begin
			case (rd_state_q)
				irqb_pkg::CH_IDLE: begin
					S_AXI_ARREADY <= !ar_fire;
					if (ar_fire) begin
						rd_state_q   <= irqb_pkg::CH_RESP;
						S_AXI_RVALID <= 1'b1;
						S_AXI_RDATA  <= rd_word;
						S_AXI_RRESP  <= rd_hit ? irqb_pkg::RESP_OKAY : irqb_pkg::RESP_SLVERR;
					end
				end
				irqb_pkg::CH_RESP: begin
					if (S_AXI_RREADY) begin
						rd_state_q    <= irqb_pkg::CH_IDLE;
						S_AXI_RVALID  <= 1'b0;
						S_AXI_ARREADY <= 1'b1;
					end
				end
				default: begin
					rd_state_q <= irqb_pkg::CH_IDLE;
				end
			endcase
		end
	end

	// Checks
	sequence flags5_write_s;
		wr_f5 && (lane_mask == 16'hffff) && (SRC_EVT.f5 == 16'h0000);
	endsequence

	pulse_sets_flag_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		(evt5 != 16'h0000) |=> ((flags_q.f5 & $past(evt5)) == $past(evt5)))
		else $error("source pulse did not set its flag");
	flag_holds_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		(!wr_f5 && (SRC_EVT.f5 == 16'h0000)) |=> (flags_q.f5 == $past(flags_q.f5)))
		else $error("flag changed without event or write");
	unimpl_zero_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		((flags_q.f5 & ~irqb_pkg::IMPL_FLAGS5) == 16'h0000) &&
		((flags_q.f6 & ~irqb_pkg::IMPL_FLAGS6) == 16'h0000) &&
		((flags_q.f7 & ~irqb_pkg::IMPL_FLAGS7) == 16'h0000) && !enable_q[15])
		else $error("unimplemented bit is set");
	reset_clear_a: assert property (@(posedge CORE_CLK)
		$rose(rst_n) |-> (flags_q == '0) && (enable_q == 16'h0000))
		else $error("register not zero after reset");
	write_value_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		flags5_write_s |=> (flags_q.f5 == ($past(wr_lo) & irqb_pkg::IMPL_FLAGS5)))
		else $error("flag write value not taken");
	req_gate_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		##1 (CPU_REQ0 == ($past(SRC0_FLAG) & $past(enable_q))))
		else $error("request not gated by enable");
	layout_bits_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		SRC_EVT.f5[irqb_pkg::F5_ADC_PAIR12] |=> flags_q.f5[irqb_pkg::F5_ADC_PAIR12] ##0
		(flags_q.f6[irqb_pkg::F6_CMP4] || !$past(SRC_EVT.f6[irqb_pkg::F6_CMP4])))
		else $error("flag landed on the wrong bit");
	pair7_bit_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		SRC_EVT.f7[irqb_pkg::F7_ADC_PAIR7] |=> flags_q.f7[irqb_pkg::F7_ADC_PAIR7])
		else $error("pair 7 flag not set");
	enable_bit_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		(wr_en0 && wr_lo[irqb_pkg::E0_DMA_CH1] && wr_strb[1]) |=> enable_q[irqb_pkg::E0_DMA_CH1])
		else $error("enable bit not stored");
	irq_level_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		##1 (IRQ == |(status_q & mask_q)))
		else $error("interrupt output disagrees with status");
	bresp_hold_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		(S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID [*1] ##0 $stable(S_AXI_BRESP))
		else $error("write response dropped early");
endmodule
`default_nettype wire

// ==== design/irqb_pkg.sv ====
// Package with register map, field layout and shared types of the flag/enable bank
package irqb_pkg;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W  = 16;
	localparam int unsigned STAT_W = 2;

	// Byte offsets on the register bus
	localparam logic [ADDR_W-1:0] OFS_FLAGS5 = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_FLAGS6 = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAGS7 = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_ENABLE0 = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK   = 5'h14;

	// Implemented bit positions; all other positions read as zero
	localparam logic [REG_W-1:0] IMPL_FLAGS5  = 16'he01e;
	localparam logic [REG_W-1:0] IMPL_FLAGS6  = 16'hc3ff;
	localparam logic [REG_W-1:0] IMPL_FLAGS7  = 16'h003f;
	localparam logic [REG_W-1:0] IMPL_ENABLE0 = 16'h7fff;
	localparam logic [REG_W-1:0] RST_REG      = 16'h0000;
	localparam logic [STAT_W-1:0] RST_STAT    = 2'h0;

	// Selected field positions
	localparam int unsigned F5_PWM_GEN2   = 15;
	localparam int unsigned F5_PWM_GEN1   = 14;
	localparam int unsigned F5_ADC_PAIR12 = 13;
	localparam int unsigned F5_ADC_PAIR8  = 1;
	localparam int unsigned F6_ADC_PAIR1  = 15;
	localparam int unsigned F6_CMP4       = 9;
	localparam int unsigned F6_CMP2       = 7;
	localparam int unsigned F6_PWM_GEN3   = 0;
	localparam int unsigned F7_ADC_PAIR7  = 5;
	localparam int unsigned F7_ADC_PAIR2  = 0;
	localparam int unsigned E0_DMA_CH1    = 14;
	localparam int unsigned E0_SPI1_ERR   = 9;
	localparam int unsigned E0_EXT_IRQ0   = 0;

	// Event status bits
	localparam int unsigned ST_FORWARD = 0;
	localparam int unsigned ST_OVERRUN = 1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [REG_W-1:0] f7;
		logic [REG_W-1:0] f6;
		logic [REG_W-1:0] f5;
	} irqb_flags_s;

	typedef enum logic [1:0] {
		CH_IDLE = 2'b01,
		CH_RESP = 2'b10
	} irqb_chan_e;
endpackage

// ==== tb/irqb_src_model.sv ====
// Model of the event sources and the request levels feeding the bank
`timescale 1ns/1ps
`default_nettype none
module irqb_src_model (
	input  wire logic                  clk,
	output var  irqb_pkg::irqb_flags_s evt,
	output var  logic [15:0]           lvl
);
	initial begin
		evt = '0;
		lvl = 16'h0000;
	end
	// Sources raise a request for exactly one clock
	task automatic pulse(input irqb_pkg::irqb_flags_s p);
		@(posedge clk);
		evt <= p;
		@(posedge clk);
		evt <= '0;
	endtask
	task automatic level(input logic [15:0] v);
		@(posedge clk);
		lvl <= v;
	endtask
endmodule
`default_nettype wire

// ==== tb/test_irq_flag_enable_bank.sv ====
// Self-checking bench for the flag and enable bank
`timescale 1ns/1ps
`default_nettype none
module test_irq_flag_enable_bank;
	logic                  clk = 1'b0;
	logic                  arst_n = 1'b1;
	logic [3:0]            wstrb = 4'hf;
	logic [4:0]            awaddr = 5'h00;
	logic [4:0]            araddr = 5'h00;
	logic [31:0]           wdata = 32'h0;
	logic [31:0]           rdata;
	logic                  awvalid = 1'b0;
	logic                  wvalid = 1'b0;
	logic                  bready = 1'b0;
	logic                  arvalid = 1'b0;
	logic                  rready = 1'b0;
	logic                  awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]            bresp, rresp;
	irqb_pkg::irqb_flags_s evt, pend;
	logic [15:0]           lvl, req;
	int                    miscompares = 0;
	int                    check_count = 0;
	always #25 clk = ~clk;
	irqb_src_model irqb_src_model_i (.clk(clk), .evt(evt), .lvl(lvl));
	irqb_bank irqb_bank_i (
		.CORE_CLK(clk), .ARST_N(arst_n), .SRC_EVT(evt), .SRC0_FLAG(lvl),
		.PEND_FLAGS(pend), .CPU_REQ0(req), .IRQ(irq),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
	);
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Handshakes are judged at the falling edge, acted on at the next rising edge
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb, db;
		int n;
		db = 1'b0;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!db && n < 40) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			db = tb;
			n++;
		end
		if (!db) begin
			miscompares++;
			complete_run();
		end
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		int n;
		tr = 1'b0;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tr && n < 40) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
			n++;
		end
		if (!tr) begin
			miscompares++;
			complete_run();
		end
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk({30'h0, r}, 32'h0);
		chk(d, e);
	endtask
	task automatic t_rw;
		logic [31:0] m [4] = '{32'h0000e01e, 32'h0000c3ff, 32'h0000003f, 32'h00007fff};
		logic [1:0]  r;
		for (int i = 0; i < 4; i++) begin
			wr(5'(i * 4), 32'hffffffff, r);
			rchk(5'(i * 4), m[i]);
			wr(5'(i * 4), 32'h0, r);
			rchk(5'(i * 4), 32'h0);
		end
	endtask
	task automatic t_event;
		logic [1:0] r;
		irqb_src_model_i.pulse(48'hffffffffffff);
		@(negedge clk);
		chk({16'h0, pend.f5}, 32'h0000e01e);
		chk({16'h0, pend.f6}, 32'h0000c3ff);
		chk({16'h0, pend.f7}, 32'h0000003f);
		// A repeat hit on a held flag reports an overrun
		irqb_src_model_i.pulse(48'h000000400000);
		rchk(5'h04, 32'h0000c3ff);
		rchk(5'h10, 32'h2);
		wr(5'h10, 32'h2, r);
		rchk(5'h10, 32'h0);
		for (int i = 0; i < 3; i++) wr(5'(i * 4), 32'h0, r);
		irqb_src_model_i.pulse(48'h000100000000);
		rchk(5'h08, 32'h1);
		rchk(5'h00, 32'h0);
		wr(5'h08, 32'h0, r);
		rchk(5'h08, 32'h0);
	endtask
	task automatic t_enable;
		logic [1:0] r;
		irqb_src_model_i.level(16'hffff);
		wr(5'h0c, 32'h4201, r);
		repeat (3) @(negedge clk);
		chk({16'h0, req}, 32'h4201);
		rchk(5'h10, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(5'h14, 32'h1, r);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(5'h10, 32'h1, r);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(5'h0c, 32'h0, r);
		repeat (3) @(negedge clk);
		chk({16'h0, req}, 32'h0);
		wr(5'h14, 32'h0, r);
		irqb_src_model_i.level(16'h0000);
	endtask
	task automatic t_unmapped;
		logic [31:0] d;
		logic [1:0]  r;
		wr(5'h18, 32'hffffffff, r);
		chk({30'h0, r}, 32'h2);
		rd(5'h1c, d, r);
		chk({30'h0, r}, 32'h2);
		chk(d, 32'h0);
		rchk(5'h00, 32'h0);
	endtask
	// Byte lanes: lane 0 low byte, lane 1 high byte, lanes 2 and 3 store nothing
	task automatic t_strobe;
		logic [1:0] r;
		wstrb <= 4'h1;
		wr(5'h0c, 32'hffffffff, r);
		rchk(5'h0c, 32'h000000ff);
		wstrb <= 4'h2;
		wr(5'h0c, 32'hffffffff, r);
		rchk(5'h0c, 32'h00007fff);
		wstrb <= 4'hc;
		wr(5'h0c, 32'h0, r);
		rchk(5'h0c, 32'h00007fff);
		wstrb <= 4'h2;
		wr(5'h00, 32'hffffffff, r);
		rchk(5'h00, 32'h0000e000);
		wstrb <= 4'hf;
		wr(5'h00, 32'h0, r);
		wr(5'h0c, 32'h0, r);
		rchk(5'h00, 32'h0);
		rchk(5'h0c, 32'h0);
	endtask
	// Reset in mid-run clears flags set by the sources
	task automatic t_reset;
		irqb_src_model_i.pulse(48'hffffffffffff);
		rchk(5'h00, 32'h0000e01e);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		chk({16'h0, pend.f5}, 32'h0);
		chk({16'h0, pend.f6}, 32'h0);
		chk({16'h0, pend.f7}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rchk(5'h04, 32'h0);
		rchk(5'h10, 32'h0);
	endtask
	initial begin
		arst_n <= 1'b0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 6; i++) rchk(5'(i * 4), 32'h0);
		t_rw();
		t_event();
		t_enable();
		t_unmapped();
		t_strobe();
		t_reset();
		complete_run();
	end
endmodule
`default_nettype wire
